// file: ncb_host.sv
// module: apb-driven host sequencer for copy-back, id, status and ecc-status reads
// How it works
// - copy-back program opens with 85h plus destination address, no data reload
// - modified program sends 85h with new column and one data byte
// - software keeps source and destination in one district
// - completion taken from ready_busy_output pin, then status bit zero checked
// - after load, host reads status to take the rewrite bit (status bit three)
// - status command 70h, then byte sampled on read strobe
// - fail bit only taken while status reports ready
// - only status reads are issued while device reports busy
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module ncb_host #(
   parameter logic [7:0] ECC_CMD = ncb_pkg::CMD_ECC_DEF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             chip_en_n,
   output logic             cmd_latch,
   output logic             addr_latch,
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic             write_prot_n,
   output logic [7:0]       io_out,
   output logic             io_oe,
   input  wire logic [7:0]  io_in,
   input  wire logic        ready_busy_output
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      ncb_pkg::ncb_state_t st;
      logic [3:0]  tmr;
      logic        ph;       // second half of a strobe
      logic [2:0]  idx;
      logic [2:0]  op;
      logic [7:0]  cmd;
      logic [39:0] addr;     // source row/col
      logic [39:0] dst;
      logic [15:0] col;
      logic [7:0]  wdat;
      logic        busy;
      logic        done;
      logic        fail;
      logic        uncorr;
      logic        rewr;
      logic [7:0]  nstat;
      logic [39:0] id;
      logic [31:0] ecc;
      logic [31:0] prdata;
      logic        pready;
      logic        ce_n, cle, ale, we_n, re_n, wp_n;
      logic [7:0]  io;
      logic        oe;
      logic [1:0]  rb_s;     // pin synchroniser
      logic [7:0]  io_s1, io_s2;
   } ncb_reg_t;

   ncb_reg_t q, d;
   logic     acc, wr, rd, ready_s;
   assign acc     = psel && penable;
   assign wr      = acc && pwrite && q.pready;
   assign rd      = acc && !pwrite && !q.pready;
   assign ready_s = q.rb_s[1];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d          = q;
      d.rb_s     = {q.rb_s[0], ready_busy_output};
      d.io_s1    = io_in;
      d.io_s2    = q.io_s1;
      d.wp_n     = 1'b1;
      d.pready   = acc && !q.pready;
      if (rd) begin
         case (paddr)
            ncb_pkg::OFF_CTRL:  d.prdata = {29'h0000_0000, q.op};
            ncb_pkg::OFF_ADDR:  d.prdata = q.addr[31:0];
            ncb_pkg::OFF_COL:   d.prdata = {16'h0000, q.col};
            ncb_pkg::OFF_WDATA: d.prdata = {24'h00_0000, q.wdat};
            ncb_pkg::OFF_STAT:  d.prdata = {27'h000_0000, q.rewr, q.uncorr, q.fail, q.done, q.busy};
            ncb_pkg::OFF_NSTAT: d.prdata = {24'h00_0000, q.nstat};
            ncb_pkg::OFF_ID0:   d.prdata = q.id[31:0];
            ncb_pkg::OFF_ID1:   d.prdata = {24'h00_0000, q.id[39:32]};
            ncb_pkg::OFF_ECC:   d.prdata = q.ecc;
            ncb_pkg::OFF_DST:   d.prdata = q.dst[31:0];
            default:            d.prdata = 32'h0000_0000;
         endcase
      end
      if (wr && !q.busy) begin
         case (paddr)
            ncb_pkg::OFF_ADDR:  d.addr = {8'h00, pwdata};
            ncb_pkg::OFF_DST:   d.dst  = {8'h00, pwdata};
            ncb_pkg::OFF_COL:   d.col  = pwdata[15:0];
            ncb_pkg::OFF_WDATA: d.wdat = pwdata[7:0];
            ncb_pkg::OFF_CTRL: begin
               if (pwdata[ncb_pkg::CTRL_GO_BIT]) begin
                  d.op   = pwdata[ncb_pkg::CTRL_OP_LSB +: 3];
                  d.busy = 1'b1;
                  d.done = 1'b0;
                  d.st   = ncb_pkg::ST_CMD;
                  d.idx  = 3'h0;
                  case (pwdata[ncb_pkg::CTRL_OP_LSB +: 3])
                     ncb_pkg::OP_LOAD:   d.cmd = ncb_pkg::CMD_READCB;
                     ncb_pkg::OP_ID:     d.cmd = ncb_pkg::CMD_ID;
                     ncb_pkg::OP_STATUS: d.cmd = ncb_pkg::CMD_STATUS;
                     ncb_pkg::OP_ECC:    d.cmd = ECC_CMD;
                     default:            d.cmd = ncb_pkg::CMD_COPYIN;
                  endcase
               end
            end
            default: ;
         endcase
      end
      // phase timer; in wait it also spans sync lag, so a stale ready is never taken
      if (q.st != ncb_pkg::ST_IDLE && q.tmr != 4'h0) begin
         d.tmr = q.tmr - 4'h1;
      end else begin
         case (q.st)
            ncb_pkg::ST_IDLE: ;
            ncb_pkg::ST_CMD, ncb_pkg::ST_CMD2: begin
               d.ce_n = 1'b0;
               d.oe   = 1'b1;
               d.io   = q.cmd;
               d.cle  = 1'b1;
               d.ale  = 1'b0;
               d.tmr  = ncb_pkg::PHASE_CYC;
               if (!q.ph) begin
                  d.we_n = 1'b0;
                  d.ph   = 1'b1;
               end else begin
                  d.we_n = 1'b1;
                  d.ph   = 1'b0;
                  d.idx  = 3'h0;
                  if (q.st == ncb_pkg::ST_CMD2) begin
                     d.st = ncb_pkg::ST_WAITB;
                  end else if (q.op == ncb_pkg::OP_STATUS || q.op == ncb_pkg::OP_ECC) begin
                     d.st = ncb_pkg::ST_DOUT;
                  end else begin
                     d.st = ncb_pkg::ST_ADR;
                  end
               end
            end
            ncb_pkg::ST_ADR: begin
               d.cle = 1'b0;
               d.ale = 1'b1;
               d.tmr = ncb_pkg::PHASE_CYC;
               if (q.op == ncb_pkg::OP_ID) d.io = 8'h00;
               else if (q.op == ncb_pkg::OP_LOAD) d.io = q.addr[q.idx*8 +: 8];
               else d.io = q.dst[q.idx*8 +: 8];
               if (!q.ph) begin
                  d.we_n = 1'b0;
                  d.ph   = 1'b1;
               end else begin
                  d.we_n = 1'b1;
                  d.ph   = 1'b0;
                  d.idx  = q.idx + 3'h1;
                  if (q.op == ncb_pkg::OP_ID) begin
                     d.st  = ncb_pkg::ST_DOUT;
                     d.idx = 3'h0;
                  end else if (q.idx == 3'h4) begin
                     d.idx = 3'h0;
                     if (q.op == ncb_pkg::OP_LOAD) begin
                        // page of PAGE_BYTES moved by device
                        d.cmd = ncb_pkg::CMD_CONFIRM;
                        d.st  = ncb_pkg::ST_WAITB;
                     end else if (q.op == ncb_pkg::OP_MODPROG) begin
                        d.st  = ncb_pkg::ST_DIN;
                     end else begin
                        d.cmd = ncb_pkg::CMD_CONFIRM;
                        d.st  = ncb_pkg::ST_CMD2;
                     end
                  end
               end
            end
            ncb_pkg::ST_DIN: begin
               d.tmr = ncb_pkg::PHASE_CYC;
               d.ale = (q.idx != 3'h2);
               d.io  = (q.idx == 3'h2) ? q.wdat : q.col[q.idx[0]*8 +: 8];
               if (!q.ph) begin
                  d.we_n = 1'b0;
                  d.ph   = 1'b1;
               end else begin
                  d.we_n = 1'b1;
                  d.ph   = 1'b0;
                  d.idx  = q.idx + 3'h1;
                  if (q.idx == 3'h2) begin
                     d.cmd = ncb_pkg::CMD_CONFIRM;
                     d.st  = ncb_pkg::ST_CMD2;
                  end
               end
            end
            ncb_pkg::ST_WAITB: begin
               d.cle = 1'b0;
               d.oe  = 1'b0;
               // wait on pin, then read status
               if (ready_s) begin
                  d.cmd = ncb_pkg::CMD_STATUS;
                  d.op  = ncb_pkg::OP_STATUS;
                  d.st  = ncb_pkg::ST_CMD;
               end
            end
            ncb_pkg::ST_DOUT: begin
               d.cle = 1'b0;
               d.ale = 1'b0;
               d.oe  = 1'b0;
               d.tmr = ncb_pkg::PHASE_CYC;
               if (!q.ph) begin
                  d.re_n = 1'b0;
                  d.ph   = 1'b1;
               end else begin
                  d.re_n = 1'b1;
                  d.ph   = 1'b0;
                  d.idx  = q.idx + 3'h1;
                  d.st   = ncb_pkg::ST_DONE;
                  case (q.op)
                     ncb_pkg::OP_ID: begin
                        d.id[q.idx*8 +: 8] = q.io_s2;
                        if (q.idx != 3'(ncb_pkg::ID_BYTES - 1)) d.st = ncb_pkg::ST_DOUT;
                     end
                     ncb_pkg::OP_ECC: begin
                        d.ecc[q.idx*8 +: 8] = q.io_s2;
                        if (q.io_s2[3:0] == ncb_pkg::ECC_UNCORR) d.uncorr = 1'b1;
                        if (q.idx != 3'(ncb_pkg::ECC_SECTORS - 1)) d.st = ncb_pkg::ST_DOUT;
                     end
                     default: begin
                        d.nstat = q.io_s2;
                        if (q.io_s2[ncb_pkg::SB_READY]) begin
                           d.fail   = q.io_s2[ncb_pkg::SB_FAIL];
                           d.rewr   = q.io_s2[ncb_pkg::SB_REWR];
                        end
                     end
                  endcase
               end
            end
            ncb_pkg::ST_DONE: begin
               d.ce_n = 1'b1;
               d.busy = 1'b0;
               d.done = 1'b1;
               d.st   = ncb_pkg::ST_IDLE;
            end
            default: d.st = ncb_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // registers; clk_en freezes everything
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q      <= '0;
         q.ce_n <= 1'b1;
         q.we_n <= 1'b1;
         q.re_n <= 1'b1;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign prdata         = q.prdata;
   assign pready         = q.pready;
   assign pslverr        = 1'b0;
   assign chip_en_n      = q.ce_n;
   assign cmd_latch      = q.cle;
   assign addr_latch     = q.ale;
   assign write_strobe_n = q.we_n;
   assign read_strobe_n  = q.re_n;
   assign write_prot_n   = q.wp_n;
   assign io_out         = q.io;
   assign io_oe          = q.oe;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_confirm_last;
      @(posedge pclk) disable iff (!presetn)
      (q.st == ncb_pkg::ST_CMD2 && d.st == ncb_pkg::ST_WAITB) |-> q.cmd == ncb_pkg::CMD_CONFIRM;
   endproperty
   a_confirm_last: assert property (p_confirm_last) else $error("confirm not last");
   property p_busy_cmd;
      @(posedge pclk) disable iff (!presetn)
      (q.st == ncb_pkg::ST_WAITB && !ready_s) |=> q.st == ncb_pkg::ST_WAITB || !clk_en;
   endproperty
   a_busy_cmd: assert property (p_busy_cmd) else $error("left wait while busy");
   property p_ctl_excl;
      @(posedge pclk) disable iff (!presetn)
      !(q.cle && q.ale) && !(q.oe && !q.re_n);
   endproperty
   a_ctl_excl: assert property (p_ctl_excl) else $error("latch clash");
   property p_pready;
      @(posedge pclk) disable iff (!presetn)
      (acc && !q.pready && clk_en) |=> pready;
   endproperty
   a_pready: assert property (p_pready) else $error("apb not answered");
   property p_ready_status; @(posedge pclk) disable iff (!presetn)
      (q.st == ncb_pkg::ST_WAITB && ready_s && q.tmr == 4'h0 && clk_en)
      |=> (q.st == ncb_pkg::ST_CMD && q.cmd == ncb_pkg::CMD_STATUS); endproperty
   a_ready_status: assert property (p_ready_status) else $error("no status read after ready");
   property p_id_zero; @(posedge pclk) disable iff (!presetn)
      (q.st == ncb_pkg::ST_ADR && q.op == ncb_pkg::OP_ID && !q.we_n) |-> q.io == 8'h00; endproperty
   a_id_zero: assert property (p_id_zero) else $error("id address not zero");
endmodule

// file: ncb_pkg.sv
// package: register map, command codes and timing constants for the copy-back host controller
package ncb_pkg;
   // ----------------------------------------
   // register offsets (apb byte addresses)
   // ----------------------------------------
   localparam logic [11:0] OFF_CTRL   = 12'h000;
   localparam logic [11:0] OFF_ADDR   = 12'h004;
   localparam logic [11:0] OFF_COL    = 12'h008;
   localparam logic [11:0] OFF_WDATA  = 12'h00C;
   localparam logic [11:0] OFF_STAT   = 12'h010;
   localparam logic [11:0] OFF_NSTAT  = 12'h014;
   localparam logic [11:0] OFF_ID0    = 12'h018;
   localparam logic [11:0] OFF_ID1    = 12'h01C;
   localparam logic [11:0] OFF_ECC    = 12'h020;
   localparam logic [11:0] OFF_DST    = 12'h024;
   // ----------------------------------------
   // control and status fields
   // ----------------------------------------
   localparam int CTRL_GO_BIT  = 0;
   localparam int CTRL_OP_LSB  = 4;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_DONE    = 1;
   localparam int STAT_FAIL    = 2;
   localparam int STAT_UNCORR  = 3;
   localparam int STAT_REWR    = 4;
   // ----------------------------------------
   // operations selected by software
   // ----------------------------------------
   localparam logic [2:0] OP_LOAD   = 3'h0;
   localparam logic [2:0] OP_PROG   = 3'h1;
   localparam logic [2:0] OP_MODPROG= 3'h2;
   localparam logic [2:0] OP_ID     = 3'h3;
   localparam logic [2:0] OP_STATUS = 3'h4;
   localparam logic [2:0] OP_ECC    = 3'h5;
   // ----------------------------------------
   // flash command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_READ0   = 8'h00;
   localparam logic [7:0] CMD_READCB  = 8'h35;
   localparam logic [7:0] CMD_COPYIN  = 8'h85;
   localparam logic [7:0] CMD_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_STATUS  = 8'h70;
   localparam logic [7:0] CMD_ID      = 8'h90;
   localparam logic [7:0] CMD_ECC_DEF = 8'h7A;   // arbitrary default, code not published
   // ----------------------------------------
   // status byte and ecc byte fields
   // ----------------------------------------
   localparam int SB_FAIL   = 0;
   localparam int SB_REWR   = 3;
   localparam int SB_READY  = 6;
   localparam logic [3:0] ECC_UNCORR = 4'hF;
   localparam logic [3:0] ECC_MAXCOR = 4'h8;
   localparam int         ID_BYTES   = 5;
   localparam int         ECC_SECTORS= 4;
   localparam int         PAGE_BYTES = 2112;
   // ----------------------------------------
   // timing: one strobe phase, in ns
   // ----------------------------------------
   localparam int CLK_NS      = 10;
   localparam int PHASE_NS    = 30;
   localparam logic [3:0] PHASE_CYC = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
   // ----------------------------------------
   // sequencer states
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_CMD   = 4'b0001,
      ST_ADR   = 4'b0011,
      ST_WAITB = 4'b0010,
      ST_DIN   = 4'b0110,
      ST_DOUT  = 4'b0111,
      ST_CMD2  = 4'b0101,
      ST_DONE  = 4'b0100
   } ncb_state_t;
endpackage

// file: ncb_flash_model.sv
// file: behavioural flash device answering the copy-back host controller
`timescale 1ns/10ps
module ncb_flash_model #(
   parameter logic [7:0] MAKER_ID  = 8'h5A,   // arbitrary value
   parameter logic [7:0] DEVICE_ID = 8'hC3,   // arbitrary value
   parameter logic [7:0] ECC_CMD   = 8'h7A,
   parameter int         BUSY_NS   = 2000
) (
   input  wire logic       chip_en_n,
   input  wire logic       cmd_latch,
   input  wire logic       addr_latch,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic       write_prot_n,
   input  wire logic [7:0] io_out,
   output logic [7:0]      io_in,
   output logic            ready_busy_output
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] page_buf [0:2111];
   logic [7:0] id_bytes [0:4];
   logic [7:0] ecc_bytes [0:3];
   logic [7:0] cmd_q, a_last, a_prev, last_q, stat_b, out_byte;
   logic       fail_q, rewr_q, armed_q, fail_next, rewr_next;
   int         acnt, rd_idx, loads, progs, bad_cmds;
   event       go_busy;
   initial begin
      id_bytes  = '{MAKER_ID, DEVICE_ID, 8'h90, 8'h15, 8'hF6};
      ecc_bytes = '{8'h00, 8'h13, 8'h28, 8'h3F};
      ready_busy_output = 1'b1;
      {cmd_q, a_last, a_prev, last_q} = '0;
      {fail_q, rewr_q, armed_q} = '0;
      {acnt, rd_idx, loads, progs, bad_cmds} = '0;
   end
   // ----------------------------------------
   // command, address and data cycles
   // ----------------------------------------
   always @(posedge write_strobe_n) if (!chip_en_n) begin
      if (cmd_latch) begin
         if (!ready_busy_output && io_out != 8'h70) bad_cmds++;
         cmd_q = io_out;
         acnt = 0;
         rd_idx = 0;
         // program only on confirm after copy-in
         if (io_out == 8'h10 && armed_q) begin
            armed_q = 1'b0;
            progs++;
            fail_q = fail_next;
            rewr_q = 1'b0;
            -> go_busy;
         end
         if (io_out == 8'h85) armed_q = 1'b1;
      end else if (addr_latch) begin
         a_prev = a_last;
         a_last = io_out;
         acnt++;
         // whole page moved into the buffer
         if (cmd_q == 8'h35 && acnt == 5) begin
            loads++;
            for (int i = 0; i < 2112; i++) page_buf[i] = i[7:0];
            rewr_q = rewr_next;
            fail_q = 1'b0;
            -> go_busy;
         end
      end else if (cmd_q == 8'h85) begin
         page_buf[{a_last[3:0], a_prev}] = io_out;
      end
   end
   always @(go_busy) begin
      ready_busy_output = 1'b0;
      #(BUSY_NS);
      ready_busy_output = 1'b1;
   end
   // ----------------------------------------
   // read data; released bus shows inverse
   // ----------------------------------------
   always @(posedge read_strobe_n) if (!chip_en_n) begin
      last_q = out_byte;
      rd_idx++;
   end
   assign stat_b = {write_prot_n, ready_busy_output, ready_busy_output, 1'b0, rewr_q, 2'b00, fail_q};
   assign out_byte = (cmd_q == 8'h70) ? stat_b : (cmd_q == 8'h90) ? id_bytes[rd_idx % 5] :
                     (cmd_q == ECC_CMD) ? ecc_bytes[rd_idx % 4] : page_buf[rd_idx];
   assign io_in = (!chip_en_n && !read_strobe_n) ? out_byte : ~last_q;
endmodule

// file: nand_copyback_id_status_test.sv
// file: apb-driven testbench for the copy-back host controller
`timescale 1ns/10ps
module nand_copyback_id_status_test;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, chip_en_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, write_prot_n, io_oe;
   logic [7:0]  io_out, io_in;
   logic        ready_busy_output;
   int          n_errors = 0;
   int          num_checks = 0;
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value at %0t: %s", $time, msg); end end
   ncb_host uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
      .chip_en_n(chip_en_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .write_prot_n(write_prot_n), .io_out(io_out), .io_oe(io_oe),
      .io_in(io_in), .ready_busy_output(ready_busy_output));
   ncb_flash_model #(.ECC_CMD(ncb_pkg::CMD_ECC_DEF)) model (.chip_en_n(chip_en_n), .cmd_latch(cmd_latch),
      .addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .write_prot_n(write_prot_n), .io_out(io_out), .io_in(io_in), .ready_busy_output(ready_busy_output));
   // ----------------------------------------
   // closing report
   // ----------------------------------------
   task automatic print_verdict();
      $display("checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------
   // apb master tasks
   // ----------------------------------------
   task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         print_verdict();
      end
   endtask
   // software starts an op and polls until done and idle
   task automatic run_op(input logic [2:0] op);
      int n;
      apb_xfer(1'b1, ncb_pkg::OFF_CTRL, (32'(op) << ncb_pkg::CTRL_OP_LSB) | 32'h0000_0001);
      for (n = 0; n < 2000; n++) begin
         apb_xfer(1'b0, ncb_pkg::OFF_STAT, 32'h0000_0000);
         if (rd[ncb_pkg::STAT_BUSY] === 1'b0 && rd[ncb_pkg::STAT_DONE] === 1'b1) break;
      end
      if (n >= 2000) begin
         n_errors++;
         print_verdict();
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite} = '0;
      paddr = '0;
      pwdata = '0;
      model.fail_next = 1'b0;
      model.rewr_next = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb_xfer(1'b0, 12'h100, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000, "unmapped read")
      run_op(ncb_pkg::OP_ID);
      apb_xfer(1'b0, ncb_pkg::OFF_ID0, 32'h0000_0000);
      `CHK(rd, {8'h15, 8'h90, model.DEVICE_ID, model.MAKER_ID}, "id bytes one to four")
      apb_xfer(1'b0, ncb_pkg::OFF_ID1, 32'h0000_0000);
      `CHK(rd[7:0], 8'hF6, "id byte five")
      run_op(ncb_pkg::OP_STATUS);
      apb_xfer(1'b0, ncb_pkg::OFF_NSTAT, 32'h0000_0000);
      `CHK(rd[7:0], 8'hE0, "plain status byte")
      `CHK({io_oe, chip_en_n, write_prot_n}, 3'b011, "bus released, not protected")
      apb_xfer(1'b1, ncb_pkg::OFF_ADDR, 32'h0001_0000);
      model.rewr_next = 1'b1;
      run_op(ncb_pkg::OP_LOAD);
      `CHK(rd[ncb_pkg::STAT_REWR], 1'b1, "rewrite flag after load")
      `CHK(model.loads, 1, "one page load")
      apb_xfer(1'b0, ncb_pkg::OFF_NSTAT, 32'h0000_0000);
      `CHK(rd[7:0], 8'hE8, "status after load")
      model.fail_next = 1'b1;
      apb_xfer(1'b1, ncb_pkg::OFF_DST, 32'h0000_0200);
      run_op(ncb_pkg::OP_PROG);
      `CHK(rd[ncb_pkg::STAT_FAIL], 1'b1, "fail flag after program")
      `CHK(model.progs, 1, "one program after confirm")
      `CHK(model.page_buf[12'h123], 8'h23, "buffer kept without reload")
      apb_xfer(1'b0, ncb_pkg::OFF_NSTAT, 32'h0000_0000);
      `CHK(rd[7:0], 8'hE1, "status after failed program")
      model.fail_next = 1'b0;
      apb_xfer(1'b1, ncb_pkg::OFF_COL, 32'h0000_0123);
      apb_xfer(1'b1, ncb_pkg::OFF_WDATA, 32'h0000_00A5);
      run_op(ncb_pkg::OP_MODPROG);
      `CHK(model.page_buf[12'h123], 8'hA5, "modified buffer byte")
      `CHK(model.progs, 2, "second program")
      `CHK(rd[ncb_pkg::STAT_FAIL], 1'b0, "pass after modified program")
      run_op(ncb_pkg::OP_ECC);
      `CHK(rd[ncb_pkg::STAT_UNCORR], 1'b1, "uncorrectable sector flagged")
      apb_xfer(1'b0, ncb_pkg::OFF_ECC, 32'h0000_0000);
      `CHK(rd, 32'h3F28_1300, "ecc bytes per sector")
      `CHK(model.bad_cmds, 0, "command while busy")
      print_verdict();
   end
endmodule
